// ---- rtl/pmc_power_ctrl.sv ----
// Notes on behaviour
// - Main source, field 00, div8 clear: CPU gets every main tick.
// - Field 01, 10, 11 divide main by 2, 4, 16; div8 select divides by 8.
// - Ring select 1 runs CPU and peripherals from ring oscillator, same dividers.
// - Ring clock output runs for timer Y while ring_osc_off is 0.
// - Sleep request enters wait: CPU enable stops, oscillators keep running.
// - Wait with gate bit set stops peripheral ticks and ADC clock.
// - Pin hold output is high throughout wait and stop.
// - Wait ends on reset or a qualifying interrupt; CPU clock returns at the next divider period end.
// - Wake from wait keeps the source and divider used before sleeping.
// - With gate set, only externally clocked interrupt lines wake from wait.
// - Stop turns off both oscillators and every derived clock.
// - Writing all_clock_stop 1 enters stop and sets div8 and drive-high.
// - Stop ends only on reset or externally clocked interrupt lines.
// - In stop the oscillator output pin drives high if pin select is 1.
// - Wake from stop uses previous source divided by 8.
// - Detected main halt forces ring source, flag, ring on, interrupt.
// - Halt interrupt uses the watchdog vector; flag and bits identify it.
// - After reset: ring source, divide by 8, main oscillator stopped.
// - Main oscillator starts only on clearing main_osc_off with pin select 1.
`timescale 1ns/1ns
`default_nettype none
module pmc_power_ctrl (
   input  wire logic       i_clk_sys,
   input  wire logic       i_rst,
   input  wire logic [1:0] i_addr,
   input  wire logic [7:0] i_wdata,
   input  wire logic       i_wr,
   input  wire logic       i_rd,
   output logic      [7:0] o_rdata,
   input  wire logic       i_main_tick,
   input  wire logic       i_ring_tick,
   input  wire logic       i_wait_exec,
   input  wire logic [5:0] i_irq_req,
   output logic            o_cpu_clk_en,
   output logic            o_periph_tick,
   output logic            o_adc_clk_en,
   output logic            o_ring_clk_en,
   output logic            o_main_osc_en,
   output logic            o_ring_osc_en,
   output logic            o_osc_out_o,
   output logic            o_osc_out_oe,
   output logic            o_pin_hold,
   output logic            o_irq_osc_stop
);
   pmc_pkg::pmc_mode_e mode;
   logic                    periph_clk_wait_gate;
   logic                    main_osc_off;
   logic                    cpu_div8_select;
   logic                    osc_pin_select;
   logic                    ring_osc_off;
   logic                    main_osc_drive_high;
   logic [1:0]              cpu_divider_field;
   logic [1:0]              osc_stop_detect_enable;
   logic                    ring_osc_select;
   logic                    main_clk_stopped_flag;
   logic                    main_run;
   logic [pmc_pkg::HALT_W-1:0] halt_cnt;
   logic [3:0]              div_cnt;
   logic                    act_ring;
   logic [4:0]              act_ratio;
   logic                    wr_cm0;
   logic                    wr_cm1;
   logic                    wr_ocd;
   logic                    stop_write;
   logic                    main_live;
   logic                    ring_live;
   logic                    src_tick;
   logic                    cpu_fire;
   logic                    halt_watch;
   logic                    fallback;
   logic                    periph_on;
   logic [5:0]              wake_mask;

   assign wr_cm0     = i_wr && (i_addr == pmc_pkg::ADDR_CM0);
   assign wr_cm1     = i_wr && (i_addr == pmc_pkg::ADDR_CM1);
   assign wr_ocd     = i_wr && (i_addr == pmc_pkg::ADDR_OCD);
   assign stop_write = wr_cm1 && i_wdata[pmc_pkg::CM1_STOP] && (mode == pmc_pkg::PMC_RUN);
   assign main_live  = i_main_tick && o_main_osc_en;
   assign ring_live  = i_ring_tick && o_ring_osc_en;
   assign src_tick   = act_ring ? ring_live : main_live;
   assign cpu_fire   = src_tick && (div_cnt == 4'(act_ratio - 5'h01)) && !fallback;
   // Watch only while the CPU really runs on the main clock and detection is armed
   assign halt_watch = (osc_stop_detect_enable == pmc_pkg::DET_ON) && !act_ring &&
                       (mode != pmc_pkg::PMC_STOP) && !i_main_tick;
   assign fallback   = halt_watch && (halt_cnt == pmc_pkg::HALT_W'(pmc_pkg::HALT_CYC - 1));
   assign wake_mask  = periph_clk_wait_gate ? pmc_pkg::EXT_MASK : 6'h3F;
   assign periph_on  = (mode == pmc_pkg::PMC_RUN) ||
                       ((mode == pmc_pkg::PMC_WAIT) && !periph_clk_wait_gate);

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         mode <= pmc_pkg::PMC_RUN;
      end else begin
         case (mode)
            pmc_pkg::PMC_RUN: begin
               if (stop_write) begin
                  mode <= pmc_pkg::PMC_STOP;
               end else if (i_wait_exec) begin
                  mode <= pmc_pkg::PMC_WAIT;
               end
            end
            pmc_pkg::PMC_WAIT: begin
               if (|(i_irq_req & wake_mask)) begin
                  mode <= pmc_pkg::PMC_RUN;
               end
            end
            pmc_pkg::PMC_STOP: begin
               if (|(i_irq_req & pmc_pkg::EXT_MASK)) begin
                  mode <= pmc_pkg::PMC_RUN;
               end
            end
            default: mode <= pmc_pkg::PMC_RUN;
         endcase
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         periph_clk_wait_gate <= pmc_pkg::RST_GATE;
         main_osc_off         <= pmc_pkg::RST_MAINOFF;
         cpu_div8_select      <= pmc_pkg::RST_DIV8;
      end else if (stop_write) begin
         cpu_div8_select <= 1'h1;
      end else if (wr_cm0) begin
         periph_clk_wait_gate <= i_wdata[pmc_pkg::CM0_GATE];
         main_osc_off         <= i_wdata[pmc_pkg::CM0_MAINOFF];
         cpu_div8_select      <= i_wdata[pmc_pkg::CM0_DIV8];
      end
   end

   // Start needs the pins handed to the oscillator first
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         main_run <= 1'h0;
      end else if (wr_cm0) begin
         main_run <= !i_wdata[pmc_pkg::CM0_MAINOFF] && osc_pin_select;
      end else if (!osc_pin_select) begin
         main_run <= 1'h0;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         osc_pin_select      <= pmc_pkg::RST_PINSEL;
         ring_osc_off        <= pmc_pkg::RST_RINGOFF;
         main_osc_drive_high <= pmc_pkg::RST_DRIVE;
         cpu_divider_field   <= pmc_pkg::RST_DIV;
      end else begin
         if (fallback) begin
            ring_osc_off <= 1'h0;
         end else if (wr_cm1) begin
            ring_osc_off <= i_wdata[pmc_pkg::CM1_RINGOFF];
         end
         if (stop_write) begin
            main_osc_drive_high <= 1'h1;
         end else if (wr_cm1) begin
            main_osc_drive_high <= i_wdata[pmc_pkg::CM1_DRIVE];
         end
         if (wr_cm1) begin
            osc_pin_select    <= i_wdata[pmc_pkg::CM1_PINSEL];
            cpu_divider_field <= i_wdata[pmc_pkg::CM1_DIV_LO+:2];
         end
      end
   end

   // Hardware set beats a software clear landing in the same cycle
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         osc_stop_detect_enable <= pmc_pkg::RST_DET;
         ring_osc_select        <= pmc_pkg::RST_RSEL;
         main_clk_stopped_flag  <= 1'h0;
      end else begin
         if (wr_ocd) begin
            osc_stop_detect_enable <= i_wdata[pmc_pkg::OCD_DET_LO+:2];
         end
         if (fallback) begin
            ring_osc_select       <= 1'h1;
            main_clk_stopped_flag <= 1'h1;
         end else if (wr_ocd) begin
            ring_osc_select <= i_wdata[pmc_pkg::OCD_RSEL];
            if (!i_wdata[pmc_pkg::OCD_FLAG]) begin
               main_clk_stopped_flag <= 1'h0;
            end
         end
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         halt_cnt <= '0;
      end else if (!halt_watch || fallback) begin
         halt_cnt <= '0;
      end else begin
         halt_cnt <= halt_cnt + pmc_pkg::HALT_W'(1);
      end
   end

   // New source and ratio load only after the last tick of a whole CPU period,
   // so no shortened CPU pulse can appear. A dead main clock is abandoned at once.
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         div_cnt   <= 4'h0;
         act_ring  <= pmc_pkg::RST_RSEL;
         act_ratio <= pmc_pkg::RST_RATIO;
      end else if (fallback) begin
         div_cnt   <= 4'h0;
         act_ring  <= 1'h1;
         act_ratio <= pmc_pkg::pmc_ratio(cpu_div8_select, cpu_divider_field);
      end else if (cpu_fire) begin
         div_cnt   <= 4'h0;
         act_ring  <= ring_osc_select;
         act_ratio <= pmc_pkg::pmc_ratio(cpu_div8_select, cpu_divider_field);
      end else if (src_tick) begin
         div_cnt <= div_cnt + 4'h1;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         o_cpu_clk_en   <= 1'h0;
         o_periph_tick  <= 1'h0;
         o_adc_clk_en   <= 1'h0;
         o_ring_clk_en  <= 1'h0;
         o_irq_osc_stop <= 1'h0;
      end else begin
         o_cpu_clk_en   <= cpu_fire && (mode == pmc_pkg::PMC_RUN);
         o_periph_tick  <= periph_on && (ring_osc_select ? ring_live : main_live);
         o_adc_clk_en   <= periph_on && main_live;
         o_ring_clk_en  <= ring_live && !ring_osc_off;
         o_irq_osc_stop <= fallback;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         o_main_osc_en <= 1'h0;
         o_ring_osc_en <= 1'h1;
         o_osc_out_o   <= 1'h0;
         o_osc_out_oe  <= 1'h0;
         o_pin_hold    <= 1'h0;
      end else begin
         o_main_osc_en <= main_run && (mode != pmc_pkg::PMC_STOP) && !stop_write;
         o_ring_osc_en <= (!ring_osc_off || ring_osc_select || fallback) &&
                          (mode != pmc_pkg::PMC_STOP) && !stop_write;
         o_osc_out_o   <= (mode == pmc_pkg::PMC_STOP) && osc_pin_select;
         o_osc_out_oe  <= (mode == pmc_pkg::PMC_STOP) && osc_pin_select;
         o_pin_hold    <= (mode != pmc_pkg::PMC_RUN);
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_rst || !i_rd) begin
         o_rdata <= 8'h00;
      end else begin
         case (i_addr)
            pmc_pkg::ADDR_CM0: o_rdata <= {1'h0, cpu_div8_select, main_osc_off, 1'h0, 1'h1,
                                           periph_clk_wait_gate, 2'h0};
            pmc_pkg::ADDR_CM1: o_rdata <= {cpu_divider_field, main_osc_drive_high, ring_osc_off,
                                           osc_pin_select, 2'h0, mode == pmc_pkg::PMC_STOP};
            pmc_pkg::ADDR_OCD: o_rdata <= {4'h0, main_clk_stopped_flag, ring_osc_select,
                                           osc_stop_detect_enable};
            default:           o_rdata <= 8'h00;
         endcase
      end
   end

   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (i_rst);

   property p_stop_entry;
      stop_write |=> (mode == pmc_pkg::PMC_STOP) && cpu_div8_select && main_osc_drive_high;
   endproperty
   a_stop_entry: assert property (p_stop_entry) else $error("stop entry did not force div8/drive");
   property p_fallback;
      fallback |=> ring_osc_select && main_clk_stopped_flag && !ring_osc_off && o_irq_osc_stop && act_ring;
   endproperty
   a_fallback: assert property (p_fallback) else $error("fallback state incomplete");
   property p_stop_osc_off;
      (mode == pmc_pkg::PMC_STOP)[*2] |-> !o_main_osc_en && !o_ring_osc_en && !o_cpu_clk_en && !o_periph_tick;
   endproperty
   a_stop_osc_off: assert property (p_stop_osc_off) else $error("clock running in stop");
   property p_wait_cpu_off;
      (mode == pmc_pkg::PMC_WAIT)[*2] |-> !o_cpu_clk_en;
   endproperty
   a_wait_cpu_off: assert property (p_wait_cpu_off) else $error("CPU clock in wait");
   property p_wait_gate;
      ((mode == pmc_pkg::PMC_WAIT) && periph_clk_wait_gate)[*2] |-> !o_periph_tick && !o_adc_clk_en;
   endproperty
   a_wait_gate: assert property (p_wait_gate) else $error("peripheral clock in gated wait");
   property p_pin_hold;
      (mode != pmc_pkg::PMC_RUN) |=> o_pin_hold;
   endproperty
   a_pin_hold: assert property (p_pin_hold) else $error("pins not held");
   property p_gate_no_internal_wake;
      (mode == pmc_pkg::PMC_WAIT) && periph_clk_wait_gate && !(|(i_irq_req & pmc_pkg::EXT_MASK))
         |=> (mode == pmc_pkg::PMC_WAIT);
   endproperty
   a_gate_no_internal_wake: assert property (p_gate_no_internal_wake) else $error("internal wake");
   property p_stop_wake;
      (mode == pmc_pkg::PMC_STOP) && i_irq_req[pmc_pkg::IRQ_KEY] |=> (mode == pmc_pkg::PMC_RUN);
   endproperty
   a_stop_wake: assert property (p_stop_wake) else $error("key interrupt did not leave stop");
   property p_stop_pin;
      (mode == pmc_pkg::PMC_STOP) && osc_pin_select |=> o_osc_out_oe && o_osc_out_o;
   endproperty
   a_stop_pin: assert property (p_stop_pin) else $error("oscillator pin not high in stop");
   property p_ratio_hold;
      src_tick && !cpu_fire && !fallback |=> $stable(act_ratio) && $stable(act_ring);
   endproperty
   a_ratio_hold: assert property (p_ratio_hold) else $error("divider changed mid period");
   property p_after_reset;
      $fell(i_rst) |-> act_ring && (act_ratio == 5'h08) && !o_main_osc_en;
   endproperty
   a_after_reset: assert property (@(posedge i_clk_sys) p_after_reset) else $error("bad reset state");

   c_wait_wake: cover property ((mode == pmc_pkg::PMC_WAIT) ##1 (mode == pmc_pkg::PMC_RUN));
   c_stop_wake: cover property ((mode == pmc_pkg::PMC_STOP) ##1 (mode == pmc_pkg::PMC_RUN));
   c_fallback:  cover property (fallback);
   c_main_run:  cover property (cpu_fire && !act_ring && (act_ratio == 5'h01));
endmodule : pmc_power_ctrl
`default_nettype wire

// ---- pkg/pmc_pkg.sv ----
`default_nettype none
package pmc_pkg;
   // Register indices on the plain register port
   localparam logic [1:0] ADDR_CM0 = 2'h0;
   localparam logic [1:0] ADDR_CM1 = 2'h1;
   localparam logic [1:0] ADDR_OCD = 2'h2;
   // Field positions
   localparam int CM0_GATE    = 2;
   localparam int CM0_RSV_ONE = 3;
   localparam int CM0_MAINOFF = 5;
   localparam int CM0_DIV8    = 6;
   localparam int CM1_STOP    = 0;
   localparam int CM1_PINSEL  = 3;
   localparam int CM1_RINGOFF = 4;
   localparam int CM1_DRIVE   = 5;
   localparam int CM1_DIV_LO  = 6;
   localparam int OCD_DET_LO  = 0;
   localparam int OCD_RSEL    = 2;
   localparam int OCD_FLAG    = 3;
   // Values after reset
   localparam logic       RST_GATE    = 1'h0;
   localparam logic       RST_MAINOFF = 1'h1;
   localparam logic       RST_DIV8    = 1'h1;
   localparam logic       RST_PINSEL  = 1'h0;
   localparam logic       RST_RINGOFF = 1'h0;
   localparam logic       RST_DRIVE   = 1'h1;
   localparam logic [1:0] RST_DIV     = 2'h0;
   localparam logic [1:0] RST_DET     = 2'h0;
   localparam logic       RST_RSEL    = 1'h1;
   localparam logic [4:0] RST_RATIO   = 5'h08;
   localparam logic [1:0] DET_ON      = 2'h3;
   // Wake request lines; bits 0..4 come from externally clocked sources
   localparam int         IRQ_W        = 6;
   localparam int         IRQ_KEY      = 0;
   localparam int         IRQ_EXT_PIN  = 1;
   localparam int         IRQ_TX_EVENT = 2;
   localparam int         IRQ_TY_PIN   = 3;
   localparam int         IRQ_SER_EXT  = 4;
   localparam int         IRQ_INTERNAL = 5;
   localparam logic [5:0] EXT_MASK     = 6'h1F;
   // Main clock halt timeout: twice the period of the slowest valid main clock
   localparam int CLK_PERIOD_NS = 10;
   localparam int HALT_NS       = 1000;
   localparam int HALT_CYC      = HALT_NS / CLK_PERIOD_NS;
   localparam int HALT_W        = $clog2(HALT_CYC + 1);
   typedef enum logic [1:0] {PMC_RUN, PMC_WAIT, PMC_STOP} pmc_mode_e;
   function automatic logic [4:0] pmc_ratio(input logic div8, input logic [1:0] field);
      if (div8) begin
         return 5'h08;
      end
      case (field)
         2'h0:    return 5'h01;
         2'h1:    return 5'h02;
         2'h2:    return 5'h04;
         default: return 5'h10;
      endcase
   endfunction : pmc_ratio
endpackage : pmc_pkg
`default_nettype wire

// ---- testbench/tb.sv ----
`timescale 1ns/1ns
`default_nettype none
module tb;
   logic       i_clk_sys   = 1'b0;
   logic       i_rst       = 1'b1;
   logic [1:0] i_addr      = 2'h0;
   logic [7:0] i_wdata     = 8'h00;
   logic       i_wr        = 1'b0;
   logic       i_rd        = 1'b0;
   logic       i_main_tick = 1'b0;
   logic       i_ring_tick = 1'b0;
   logic       i_wait_exec = 1'b0;
   logic [5:0] i_irq_req   = 6'h00;
   logic [7:0] o_rdata;
   logic       o_cpu_clk_en;
   logic       o_periph_tick;
   logic       o_adc_clk_en;
   logic       o_ring_clk_en;
   logic       o_main_osc_en;
   logic       o_ring_osc_en;
   logic       o_osc_out_o;
   logic       o_osc_out_oe;
   logic       o_pin_hold;
   logic       o_irq_osc_stop;
   logic [1:0] ph          = 2'h0;
   logic       main_on     = 1'b0;
   logic       ring_on     = 1'b1;
   logic [7:0] c, p, a, r;
   int         fails       = 0;
   int         tests_run   = 0;
   int         cyc         = 0;

   pmc_power_ctrl DUT (
      .i_clk_sys      (i_clk_sys),
      .i_rst          (i_rst),
      .i_addr         (i_addr),
      .i_wdata        (i_wdata),
      .i_wr           (i_wr),
      .i_rd           (i_rd),
      .o_rdata        (o_rdata),
      .i_main_tick    (i_main_tick),
      .i_ring_tick    (i_ring_tick),
      .i_wait_exec    (i_wait_exec),
      .i_irq_req      (i_irq_req),
      .o_cpu_clk_en   (o_cpu_clk_en),
      .o_periph_tick  (o_periph_tick),
      .o_adc_clk_en   (o_adc_clk_en),
      .o_ring_clk_en  (o_ring_clk_en),
      .o_main_osc_en  (o_main_osc_en),
      .o_ring_osc_en  (o_ring_osc_en),
      .o_osc_out_o    (o_osc_out_o),
      .o_osc_out_oe   (o_osc_out_oe),
      .o_pin_hold     (o_pin_hold),
      .o_irq_osc_stop (o_irq_osc_stop)
   );

   always #5 i_clk_sys = ~i_clk_sys;

   // Both oscillators tick every 4 cycles, so 128 cycles hold exactly 32 ticks of each
   always @(posedge i_clk_sys) begin
      ph          <= ph + 2'h1;
      i_ring_tick <= ring_on && (ph == 2'h0);
      i_main_tick <= main_on && (ph == 2'h2);
   end

   // Whole run takes about 5000 cycles; twice that means a hang
   always @(posedge i_clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 10000) begin
         fails++;
         wrap_up();
      end
   end

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin
         fails++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic wr(input logic [1:0] ad, input logic [7:0] d);
      @(posedge i_clk_sys);
      i_wr    <= 1'b1;
      i_addr  <= ad;
      i_wdata <= d;
      @(posedge i_clk_sys);
      i_wr    <= 1'b0;
   endtask : wr

   task automatic rd(input logic [1:0] ad, input logic [7:0] ex);
      @(posedge i_clk_sys);
      i_rd   <= 1'b1;
      i_addr <= ad;
      @(posedge i_clk_sys);
      i_rd   <= 1'b0;
      #1;
      chk(o_rdata, ex);
   endtask : rd

   // Long enough for a pending divide-by-16 period to finish and the new one to start
   task automatic settle();
      repeat (160) @(posedge i_clk_sys);
   endtask : settle

   task automatic measure();
      c = 8'h00;
      p = 8'h00;
      a = 8'h00;
      r = 8'h00;
      repeat (128) begin
         @(posedge i_clk_sys);
         #1;
         c = c + 8'(o_cpu_clk_en);
         p = p + 8'(o_periph_tick);
         a = a + 8'(o_adc_clk_en);
         r = r + 8'(o_ring_clk_en);
      end
   endtask : measure

   task automatic pulse_sleep();
      @(posedge i_clk_sys);
      i_wait_exec <= 1'b1;
      @(posedge i_clk_sys);
      i_wait_exec <= 1'b0;
      repeat (3) @(posedge i_clk_sys);
      #1;
   endtask : pulse_sleep

   task automatic wake(input int line);
      @(posedge i_clk_sys);
      i_irq_req <= 6'h01 << line;
      repeat (3) @(posedge i_clk_sys);
      i_irq_req <= 6'h00;
      repeat (3) @(posedge i_clk_sys);
      #1;
   endtask : wake

   task automatic t_reset();
      rd(pmc_pkg::ADDR_CM0, 8'h68);
      rd(pmc_pkg::ADDR_CM1, 8'h20);
      rd(pmc_pkg::ADDR_OCD, 8'h04);
      rd(2'h3, 8'h00);
      chk(8'({o_main_osc_en, o_ring_osc_en}), 8'h01);
      measure();
      chk(c, 8'h04);
      $display("test reset done");
   endtask : t_reset

   task automatic t_ring_div();
      logic [7:0] exp [4] = '{8'h20, 8'h10, 8'h08, 8'h02};
      wr(pmc_pkg::ADDR_CM0, 8'h28);
      for (int f = 0; f < 4; f++) begin
         wr(pmc_pkg::ADDR_CM1, 8'(f << 6));
         settle();
         measure();
         chk(c, exp[f]);
         chk(p, 8'h20);
      end
      $display("test ring dividers done");
   endtask : t_ring_div

   task automatic t_main();
      logic [7:0] exp [4] = '{8'h20, 8'h10, 8'h08, 8'h02};
      // Clearing main_osc_off while the pins are still ports must not start it
      wr(pmc_pkg::ADDR_CM0, 8'h08);
      rd(pmc_pkg::ADDR_CM0, 8'h08);
      chk(8'(o_main_osc_en), 8'h00);
      wr(pmc_pkg::ADDR_CM1, 8'h08);
      wr(pmc_pkg::ADDR_CM0, 8'h08);
      repeat (2) @(posedge i_clk_sys);
      #1;
      chk(8'(o_main_osc_en), 8'h01);
      main_on <= 1'b1;
      settle();
      wr(pmc_pkg::ADDR_OCD, 8'h00);
      for (int f = 0; f < 4; f++) begin
         wr(pmc_pkg::ADDR_CM1, 8'(8'h08 | (f << 6)));
         settle();
         measure();
         chk(c, exp[f]);
         chk(r, 8'h20);
      end
      wr(pmc_pkg::ADDR_CM1, 8'hD8);
      wr(pmc_pkg::ADDR_CM0, 8'h48);
      settle();
      measure();
      chk(c, 8'h04);
      chk(r, 8'h00);
      wr(pmc_pkg::ADDR_CM0, 8'h08);
      $display("test main dividers done");
   endtask : t_main

   task automatic t_wait();
      wr(pmc_pkg::ADDR_CM1, 8'h48);
      settle();
      pulse_sleep();
      chk(8'(o_pin_hold), 8'h01);
      measure();
      chk(c, 8'h00);
      chk(p, 8'h20);
      wake(pmc_pkg::IRQ_INTERNAL);
      chk(8'(o_pin_hold), 8'h00);
      settle();
      measure();
      chk(c, 8'h10);
      wr(pmc_pkg::ADDR_CM0, 8'h0C);
      pulse_sleep();
      measure();
      chk(8'({c, p, a} == 24'h0), 8'h01);
      wake(pmc_pkg::IRQ_INTERNAL);
      chk(8'(o_pin_hold), 8'h01);
      wake(pmc_pkg::IRQ_TX_EVENT);
      chk(8'(o_pin_hold), 8'h00);
      wr(pmc_pkg::ADDR_CM0, 8'h08);
      $display("test wait done");
   endtask : t_wait

   task automatic t_detect();
      int n = 0;
      wr(pmc_pkg::ADDR_OCD, 8'h03);
      main_on <= 1'b0;
      while (o_irq_osc_stop !== 1'b1 && n < 200) begin
         @(posedge i_clk_sys);
         #1;
         n++;
      end
      chk(8'(n > 90 && n < 110), 8'h01);
      rd(pmc_pkg::ADDR_OCD, 8'h0F);
      settle();
      measure();
      chk(c, 8'h10);
      main_on <= 1'b1;
      settle();
      wr(pmc_pkg::ADDR_OCD, 8'h00);
      rd(pmc_pkg::ADDR_OCD, 8'h00);
      $display("test detection done");
   endtask : t_detect

   task automatic t_stop();
      wr(pmc_pkg::ADDR_CM1, 8'h49);
      repeat (3) @(posedge i_clk_sys);
      #1;
      chk(8'({o_main_osc_en, o_ring_osc_en, o_osc_out_oe, o_osc_out_o, o_pin_hold}), 8'h07);
      rd(pmc_pkg::ADDR_CM1, 8'h69);
      rd(pmc_pkg::ADDR_CM0, 8'h48);
      measure();
      chk(8'({c, p, r} == 24'h0), 8'h01);
      wake(pmc_pkg::IRQ_INTERNAL);
      chk(8'(o_pin_hold), 8'h01);
      wake(pmc_pkg::IRQ_KEY);
      chk(8'({o_main_osc_en, o_ring_osc_en, o_osc_out_oe, o_pin_hold}), 8'h0C);
      settle();
      measure();
      chk(c, 8'h04);
      $display("test stop done");
   endtask : t_stop

   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : wrap_up

   initial begin
      repeat (20) @(posedge i_clk_sys);
      i_rst <= 1'b0;
      @(posedge i_clk_sys);
      t_reset();
      t_ring_div();
      t_main();
      t_wait();
      t_detect();
      t_stop();
      wrap_up();
   end
endmodule : tb
`default_nettype wire
